// >>> ctr_map.vh
`ifndef CTR_MAP_VH
`define CTR_MAP_VH

// Register indices; the byte address is four times the index.
`define CTR_IDX_FAULT_ONE 8'h92
`define CTR_IDX_FAULT_TWO 8'h94
`define CTR_IDX_TUNING 8'h9c
`define CTR_IDX_STATUS 8'ha0
`define CTR_ADDR_W 12

// Writable bit masks and reset values per register.
`define CTR_MASK_FAULT_ONE 32'hbfffff7f
`define CTR_MASK_FAULT_TWO 32'hffffffff
`define CTR_MASK_TUNING 32'hff1c0000
`define CTR_RST_FAULT_ONE 32'h00000000
`define CTR_RST_FAULT_TWO 32'h00000000
`define CTR_RST_TUNING 32'h00200000
// Read-only bits that read as one in the tuning register.
`define CTR_FIXED_TUNING 32'h00200000

// Tuning field positions.
`define CTR_PARITY_BIT 31
`define CTR_BLANK_MSB 30
`define CTR_BLANK_LSB 27
`define CTR_DEGL_MSB 26
`define CTR_DEGL_LSB 24
`define CTR_ALIGN_MSB 20
`define CTR_ALIGN_LSB 18

// Status bits.
`define CTR_STAT_SENSE_BIT 0
`define CTR_STAT_CMP_BIT 1

// Timing: clock rate and the unit of the blanking and deglitch codes.
`define CTR_CLK_HZ 10000000
`define CTR_TIME_UNIT_US 1
`define CTR_CYC_PER_UNIT ((`CTR_CLK_HZ / 1000000) * `CTR_TIME_UNIT_US)

`endif

// >>> ctr_regs.v
// Summary of operation
// - The tuning register sits at index 9Ch and reads 00200000h after reset.
// - Bits 30-27 of the tuning register mask zero-cross sensing for n microseconds after each PWM edge, reset zero.
// - Bits 26-24 of the tuning register give the comparator deglitch time in microseconds, reset zero.
// - Bits 20-18 of the tuning register cap the align duty at 10,15,20,25,30,40,50 or 100 percent.
// - The first fault register sits at index 92h, the second at 94h, and the first resets to zero.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "ctr_map.vh"

module ctr_regs (
	input wire ref_clk_in,
	input wire nrst_in,
	input wire [11:0] paddr_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [31:0] pwdata_in,
	input wire [3:0] pstrb_in,
	output wire [31:0] prdata_out,
	output wire pready_out,
	output wire pslverr_out,
	input wire pwm_edge_in,
	input wire bemf_cmp_in,
	output wire zc_sense_enable_out,
	output wire bemf_cmp_filtered_out,
	output wire [3:0] edge_blanking_time_out,
	output wire [2:0] comparator_deglitch_time_out,
	output reg [6:0] align_duty_pct_out,
	output wire [31:0] fault_settings_one_out,
	output wire [31:0] fault_settings_two_out
);
	localparam NREG = 3;
	localparam [95:0] MASKS = {`CTR_MASK_TUNING, `CTR_MASK_FAULT_TWO, `CTR_MASK_FAULT_ONE};
	localparam [95:0] RSTS = {`CTR_RST_TUNING, `CTR_RST_FAULT_TWO, `CTR_RST_FAULT_ONE};
	localparam [95:0] FIXED = {`CTR_FIXED_TUNING, 32'h00000000, 32'h00000000};

	// Decode one-hot: bit0 fault one, bit1 fault two, bit2 tuning, bit3 status.
	function [3:0] ctr_decode;
		input [11:0] addr;
		begin
			ctr_decode = 4'h0;
			if (addr[1:0] == 2'b00) begin
				case (addr[11:2])
					{2'b00, `CTR_IDX_FAULT_ONE}: ctr_decode = 4'h1;
					{2'b00, `CTR_IDX_FAULT_TWO}: ctr_decode = 4'h2;
					{2'b00, `CTR_IDX_TUNING}: ctr_decode = 4'h4;
					{2'b00, `CTR_IDX_STATUS}: ctr_decode = 4'h8;
					default: ctr_decode = 4'h0;
				endcase
			end
		end
	endfunction

	wire [3:0] sel_dec;
	wire setup_ph;
	wire access_ph;
	wire wr_en;
	wire [95:0] reg_flat;
	wire [95:0] read_flat;
	wire [31:0] status_word;
	wire [31:0] tuning_w;
	wire sense_en;
	wire cmp_filt;
	reg [31:0] prdata_r;
	reg [31:0] prdata_nxt;

	assign sel_dec = ctr_decode(paddr_in);
	assign setup_ph = psel_in & ~penable_in;
	assign access_ph = psel_in & penable_in;
	assign wr_en = access_ph & pwrite_in;

	// Zero-wait slave; an unmapped or misaligned address answers with an error.
	assign pready_out = 1'b1;
	assign pslverr_out = access_ph & (sel_dec == 4'h0);

	genvar g;
	genvar b;
	generate
		for (g = 0; g < NREG; g = g + 1) begin : g_reg
			localparam [31:0] MASK = MASKS[g*32 +: 32];
			localparam [31:0] RSTV = RSTS[g*32 +: 32];
			localparam [31:0] FIXV = FIXED[g*32 +: 32];
			reg [31:0] val_r;
			wire [31:0] val_nxt;
			// Each byte lane takes new data only when its strobe is set.
			for (b = 0; b < 4; b = b + 1) begin : g_lane
				assign val_nxt[b*8 +: 8] = (wr_en & sel_dec[g] & pstrb_in[b]) ?
					(pwdata_in[b*8 +: 8] & MASK[b*8 +: 8]) : val_r[b*8 +: 8];
			end
			always @(posedge ref_clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					val_r <= RSTV & MASK;
				end else begin
					val_r <= val_nxt;
				end
			end
			assign reg_flat[g*32 +: 32] = val_r;
			// Reserved bits read zero, except fixed bits that read one.
			assign read_flat[g*32 +: 32] = (val_r & MASK) | FIXV;
		end
	endgenerate

	assign tuning_w = reg_flat[95:64];
	assign fault_settings_one_out = read_flat[31:0];
	assign fault_settings_two_out = read_flat[63:32];
	assign edge_blanking_time_out = tuning_w[`CTR_BLANK_MSB:`CTR_BLANK_LSB];
	assign comparator_deglitch_time_out = tuning_w[`CTR_DEGL_MSB:`CTR_DEGL_LSB];

	assign status_word = {30'h00000000, cmp_filt, sense_en};

	// Read data is captured in the setup cycle so it is stable in the access phase.
	always @* begin
		prdata_nxt = prdata_r;
		if (setup_ph & ~pwrite_in) begin
			case (sel_dec)
				4'h1: prdata_nxt = read_flat[31:0];
				4'h2: prdata_nxt = read_flat[63:32];
				4'h4: prdata_nxt = read_flat[95:64];
				4'h8: prdata_nxt = status_word;
				default: prdata_nxt = 32'h00000000;
			endcase
		end
	end

	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			prdata_r <= 32'h00000000;
		end else begin
			prdata_r <= prdata_nxt;
		end
	end

	assign prdata_out = prdata_r;

	// Align duty limit in percent.
	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			align_duty_pct_out <= 7'h0a;
		end else begin
			case (tuning_w[`CTR_ALIGN_MSB:`CTR_ALIGN_LSB])
				3'h0: align_duty_pct_out <= 7'h0a;
				3'h1: align_duty_pct_out <= 7'h0f;
				3'h2: align_duty_pct_out <= 7'h14;
				3'h3: align_duty_pct_out <= 7'h19;
				3'h4: align_duty_pct_out <= 7'h1e;
				3'h5: align_duty_pct_out <= 7'h28;
				3'h6: align_duty_pct_out <= 7'h32;
				default: align_duty_pct_out <= 7'h64;
			endcase
		end
	end

	ctr_zc_timing u_timing (
		.ref_clk_in(ref_clk_in),
		.nrst_in(nrst_in),
		.blank_code_in(tuning_w[`CTR_BLANK_MSB:`CTR_BLANK_LSB]),
		.degl_code_in(tuning_w[`CTR_DEGL_MSB:`CTR_DEGL_LSB]),
		.pwm_edge_in(pwm_edge_in),
		.cmp_in(bemf_cmp_in),
		.sense_en_out(sense_en),
		.cmp_filt_out(cmp_filt)
	);

	assign zc_sense_enable_out = sense_en;
	assign bemf_cmp_filtered_out = cmp_filt;
endmodule // ctr_regs

// >>> ctr_regs_bench.sv
`timescale 1ns/1ps
module ctr_regs_bench;
	reg clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, pwm = 0, cmp = 0, pc = 0;
	reg [3:0] ps = 4'hf;
	reg [11:0] pa = 12'h000;
	reg [31:0] pw = 32'h0, seed = 32'hc145, v, sm, f2e = 32'h0;
	integer error_cnt = 0, samples_checked = 0, cyc = 0, i, j;
	logic [31:0] exq[$];
	logic erq[$];
	logic [6:0] dt [8] = '{7'h0a, 7'h0f, 7'h14, 7'h19, 7'h1e, 7'h28, 7'h32, 7'h64};
	wire [31:0] prd, f1, f2;
	wire prdy, sen, filt, perr;
	wire [6:0] duty;
	wire [3:0] blk;
	wire [2:0] dgl;
	always #50 clk = ~clk;
	ctr_regs uut (.ref_clk_in(clk), .nrst_in(nrst), .paddr_in(pa), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .pwdata_in(pw), .pstrb_in(ps), .prdata_out(prd), .pready_out(prdy),
		.pslverr_out(perr), .pwm_edge_in(pwm), .bemf_cmp_in(cmp), .zc_sense_enable_out(sen),
		.bemf_cmp_filtered_out(filt), .edge_blanking_time_out(blk),
		.comparator_deglitch_time_out(dgl), .align_duty_pct_out(duty),
		.fault_settings_one_out(f1), .fault_settings_two_out(f2));
	function [31:0] xs(input [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		xs = x ^ (x << 5);
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wrap_up;
		if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task xfer(input w, input [11:0] a, input [31:0] d);
		erq.push_back(a != 12'h248 && a != 12'h250 && a != 12'h270 && a != 12'h280);
		psel <= 1;
		pwr <= w;
		pa <= a;
		pw <= d;
		@(posedge clk);
		pen <= 1;
		@(posedge clk);
		while (prdy !== 1'b1) @(posedge clk);
		psel <= 0;
		pen <= 0;
		@(posedge clk);
	endtask
	task rd(input [11:0] a, input [31:0] e);
		exq.push_back(e);
		xfer(0, a, 32'h0);
	endtask
	always @(posedge clk) if (psel && pen && prdy === 1'b1 && !pwr) chk(prd, exq.pop_front());
	always @(posedge clk) if (psel && pen && prdy === 1'b1) chk({31'h0, perr}, {31'h0, erq.pop_front()});
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			error_cnt = error_cnt + 1;
			wrap_up;
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1;
		@(posedge clk);
		rd(12'h270, 32'h00200000);
		rd(12'h248, 32'h0);
		rd(12'h24c, 32'h0);
		for (i = 0; i < 8; i = i + 1) begin
			seed = xs(seed);
			v = {seed[31:21], i[2:0], seed[17:0]};
			xfer(1, 12'h270, v);
			rd(12'h270, v & 32'hff1c0000 | 32'h00200000);
			chk({25'h0, duty}, {25'h0, dt[i]});
			chk({28'h0, blk}, {28'h0, v[30:27]});
			chk({29'h0, dgl}, {29'h0, v[26:24]});
			xfer(1, 12'h248, seed);
			rd(12'h248, seed & 32'hbfffff7f);
			chk(f1, seed & 32'hbfffff7f);
			ps <= seed[11:8];
			xfer(1, 12'h250, ~seed);
			ps <= 4'hf;
			sm = {{8{seed[11]}}, {8{seed[10]}}, {8{seed[9]}}, {8{seed[8]}}};
			f2e = ~seed & sm | f2e & ~sm;
			rd(12'h250, f2e);
			chk(f2, f2e);
			xfer(1, 12'h004, seed);
			rd(12'h004, 32'h0);
			pwm <= 1;
			cmp <= seed[5];
			@(posedge clk);
			pwm <= 0;
			for (j = 1; j <= 160; j = j + 1) begin
				@(posedge clk);
				chk({31'h0, sen}, {31'h0, j > v[30:27] * 10});
				chk({31'h0, filt}, {31'h0, (j > v[26:24] * 10) ? seed[5] : pc});
			end
			pc = seed[5];
			rd(12'h280, {30'h0, seed[5], 1'b1});
		end
		nrst <= 0;
		repeat (2) @(posedge clk);
		nrst <= 1;
		@(posedge clk);
		chk({25'h0, duty}, {25'h0, dt[0]});
		rd(12'h270, 32'h00200000);
		rd(12'h248, 32'h0);
		wrap_up;
	end
endmodule // ctr_regs_bench

// >>> ctr_regs_props.sv
`timescale 1ns/1ps
module ctr_props (
	input wire ref_clk_in,
	input wire nrst_in,
	input wire [11:0] paddr_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [31:0] pwdata_in,
	input wire [3:0] pstrb_in,
	input wire [31:0] prdata_out,
	input wire pready_out,
	input wire pslverr_out,
	input wire pwm_edge_in,
	input wire zc_sense_enable_out,
	input wire [3:0] edge_blanking_time_out,
	input wire [2:0] comparator_deglitch_time_out,
	input wire [6:0] align_duty_pct_out,
	input wire [31:0] fault_settings_one_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);
	sequence tune_wr;
		psel_in && penable_in && pready_out && pwrite_in && paddr_in == 12'h270 && pstrb_in == 4'hf;
	endsequence
	sequence tune_rd;
		psel_in && !penable_in && !pwrite_in && paddr_in == 12'h270 ##1 penable_in;
	endsequence
	sequence blank_start;
		pwm_edge_in && edge_blanking_time_out != 4'h0;
	endsequence
	chk_blank_field:
		assert property (tune_wr |=> edge_blanking_time_out == $past(pwdata_in[30:27])) else $error("bad blank code");
	chk_degl_field:
		assert property (tune_wr |=> comparator_deglitch_time_out == $past(pwdata_in[26:24])) else $error("bad deglitch code");
	chk_duty_full:
		assert property (tune_wr and pwdata_in[20:18] == 3'h7 |-> ##[1:2] align_duty_pct_out == 7'h64) else $error("bad duty");
	chk_blank_hold:
		assert property (blank_start |=> !zc_sense_enable_out [*8]) else $error("sensing not blanked");
	chk_tune_fixed:
		assert property (tune_rd |-> prdata_out[23:21] == 3'h1 && prdata_out[17:0] == 18'h0) else $error("bad fixed bits");
	chk_fault_addr:
		assert property (psel_in && penable_in && paddr_in == 12'h248 |-> !pslverr_out) else $error("fault addr refused");
	chk_rsvd_zero:
		assert property (fault_settings_one_out[30] == 1'b0 && fault_settings_one_out[7] == 1'b0) else $error("reserved set");
endmodule // ctr_props
bind ctr_regs ctr_props u_props (.ref_clk_in, .nrst_in, .paddr_in, .psel_in, .penable_in, .pwrite_in,
	.pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .pwm_edge_in, .zc_sense_enable_out,
	.edge_blanking_time_out, .comparator_deglitch_time_out, .align_duty_pct_out, .fault_settings_one_out);

// >>> ctr_zc_timing.v
`timescale 1ns/1ps
`include "ctr_map.vh"

module ctr_zc_timing (
	input wire ref_clk_in,
	input wire nrst_in,
	input wire [3:0] blank_code_in,
	input wire [2:0] degl_code_in,
	input wire pwm_edge_in,
	input wire cmp_in,
	output wire sense_en_out,
	output wire cmp_filt_out
);
	localparam [31:0] CYC_UNIT_32 = `CTR_CYC_PER_UNIT;
	localparam [7:0] CYC_UNIT = CYC_UNIT_32[7:0];

	reg [7:0] blank_cnt_r;
	reg [7:0] blank_cnt_nxt;
	reg sense_r;
	reg [7:0] degl_cnt_r;
	reg filt_r;
	wire [15:0] blank_prod;
	wire [15:0] degl_prod;
	wire [7:0] blank_target;
	wire [7:0] degl_target;

	assign blank_prod = {4'h0, blank_code_in} * CYC_UNIT;
	assign degl_prod = {5'h00, degl_code_in} * CYC_UNIT;
	assign blank_target = blank_prod[7:0];
	assign degl_target = degl_prod[7:0];

	// Sensing is masked for the programmed count after each PWM edge.
	always @* begin
		blank_cnt_nxt = blank_cnt_r;
		if (pwm_edge_in) begin
			blank_cnt_nxt = blank_target;
		end else if (blank_cnt_r != 8'h00) begin
			blank_cnt_nxt = blank_cnt_r - 8'h01;
		end
	end

	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			blank_cnt_r <= 8'h00;
			sense_r <= 1'b1;
		end else begin
			blank_cnt_r <= blank_cnt_nxt;
			sense_r <= (blank_cnt_nxt == 8'h00);
		end
	end

	// The filtered output follows only after the input has differed long enough.
	always @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			degl_cnt_r <= 8'h00;
			filt_r <= 1'b0;
		end else if (cmp_in == filt_r) begin
			degl_cnt_r <= 8'h00;
		end else if (degl_cnt_r >= degl_target) begin
			filt_r <= cmp_in;
			degl_cnt_r <= 8'h00;
		end else begin
			degl_cnt_r <= degl_cnt_r + 8'h01;
		end
	end

	assign sense_en_out = sense_r;
	assign cmp_filt_out = filt_r;
endmodule // ctr_zc_timing
